// ---- pafc_config.sv ----
// address slot, enable mask and assigned frame configuration store
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module pafc_config #(
    parameter int SLOTS = pafc_pkg::SLOT_COUNT
) (
    input  wire logic                                clk_sys,
    input  wire logic                                rst,
    input  wire logic                                linkClk,
    input  wire logic                                selectN,
    input  wire logic                                mosi,
    input  wire logic [pafc_pkg::SLOT_IDX_BITS-1:0]  lookupSlot,
    input  wire logic [6:0]                          lookupFrame,
    output logic [pafc_pkg::ADDR_BITS-1:0]           slotAddr,
    output logic                                     slotLong,
    output logic                                     slotSilent,
    output logic                                     slotActive,
    output logic                                     slotReportable,
    output logic [SLOTS-1:0]                         slot_enable_bits,
    output logic                                     frameDecode,
    output logic [pafc_pkg::GROUP_BITS-1:0]          lastGroup,
    output logic                                     anyFrameSet,
    output logic                                     badPacket
);
    import pafc_pkg::*;

    // ------------------------------------------------------------------
    // packet reception
    // ------------------------------------------------------------------
    logic [PKT_BITS-1:0] pkt;
    logic                pktValid;

    // the link logic runs on the host's clock and hands whole packets over
    pafc_link_rx u_rx (
        .linkClk  (linkClk),
        .rst      (rst),
        .selectN  (selectN),
        .mosi     (mosi),
        .clk_sys  (clk_sys),
        .pktData  (pkt),
        .pktValid (pktValid)
    );

    // ------------------------------------------------------------------
    // identifier decode
    // ------------------------------------------------------------------
    wire [7:0] pktId    = pkt[31:24];
    wire [7:0] pktByte2 = pkt[23:16];
    wire [15:0] pktLow  = pkt[15:0];
    // slot packet: upper nibble 1000, lower nibble the slot number
    wire isSlot   = pktValid && (pktId[7:4] == ID_SLOT_HI)
                    && !pkt[POS_ZERO];
    wire isEnable = pktValid && (pktId == ID_ENABLE)
                    && (pktByte2 == BYTE2_ZERO);
    wire isFrame  = pktValid && (pktId[7:3] == ID_FRAME_HI)
                    && (pktByte2 == BYTE2_ZERO);
    // packets owned by other blocks (control, phase) are ignored here;
    // only malformed packets of our own identifiers are flagged
    wire ownIdBad = pktValid && !isSlot && !isEnable && !isFrame
                    && ((pktId[7:4] == ID_SLOT_HI) || (pktId == ID_ENABLE)
                        || (pktId[7:3] == ID_FRAME_HI));
    wire [SLOT_IDX_BITS-1:0] wrSlot  = pktId[SLOT_IDX_BITS-1:0];
    wire [GROUP_BITS-1:0]    wrGroup = pktId[GROUP_BITS-1:0];

    // ------------------------------------------------------------------
    // slot storage
    // ------------------------------------------------------------------
    // contents carry no reset; they are unusable until enabled anyway
    logic [ADDR_BITS-1:0] addr_r   [SLOTS];
    logic                 long_r   [SLOTS];
    logic                 silent_r [SLOTS];
    logic [SLOTS-1:0]     enable_r;
    logic [SLOTS-1:0]     enable_nxt;

    genvar s;
    generate
        for (s = 0; s < SLOTS; s++) begin : g_slot
            wire hit = isSlot && (wrSlot == SLOT_IDX_BITS'(s));
            // rewriting while enabled is the host's fault; not blocked
            always_ff @(posedge clk_sys) begin
                if (hit) begin
                    addr_r[s]   <= pkt[ADDR_BITS-1:0];
                    long_r[s]   <= pkt[POS_LONG];
                    silent_r[s] <= pkt[POS_SILENT];
                end
            end
        end
    endgenerate

    // enable mask: bit 0 belongs to slot 80H, bit 15 to 8FH
    assign enable_nxt = isEnable ? pktLow[SLOTS-1:0] : enable_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            enable_r <= ENABLE_RST[SLOTS-1:0];
        end else begin
            enable_r <= enable_nxt;
        end
    end

    // ------------------------------------------------------------------
    // frame mask
    // ------------------------------------------------------------------
    logic [FRAME_COUNT-1:0] frame_select_bits_r;
    logic [GROUP_BITS-1:0]  group_r;

    genvar g;
    generate
        for (g = 0; g < GROUP_COUNT; g++) begin : g_group
            // group g lands at frames (7-g)*16 upward
            localparam int BASE = (GROUP_COUNT - 1 - g) * FRAMES_PER_GRP;
            wire hit = isFrame && (wrGroup == GROUP_BITS'(g));
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    frame_select_bits_r[BASE +: FRAMES_PER_GRP] <= '0;
                end else if (hit) begin
                    frame_select_bits_r[BASE +: FRAMES_PER_GRP] <= pktLow;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            group_r <= GROUP_RST;
        end else if (isFrame) begin
            group_r <= wrGroup;
        end
    end

    // ------------------------------------------------------------------
    // lookup ports for the address matcher and frame scheduler
    // ------------------------------------------------------------------
    // even slot of a long pair is never reported; the second word is
    wire lkLong    = long_r[lookupSlot];
    wire lkEnabled = enable_r[lookupSlot];
    wire lkReport  = lkEnabled && (!lkLong || lookupSlot[0]);
    wire lkFrame   = frame_select_bits_r[lookupFrame];

    // registered outputs; one cycle of lookup latency
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            slotAddr         <= '0;
            slotLong         <= 1'b0;
            slotSilent       <= 1'b0;
            slotActive       <= 1'b0;
            slotReportable   <= 1'b0;
            slot_enable_bits <= '0;
            frameDecode      <= 1'b0;
            lastGroup        <= GROUP_RST;
            anyFrameSet      <= 1'b0;
            badPacket        <= 1'b0;
        end else begin
            // contents are masked until enabled, hiding unreset storage
            slotAddr         <= lkEnabled ? addr_r[lookupSlot] : '0;
            slotLong         <= lkEnabled && lkLong;
            slotSilent       <= lkEnabled && silent_r[lookupSlot];
            slotActive       <= lkEnabled;
            slotReportable   <= lkReport;
            slot_enable_bits <= enable_r;
            frameDecode      <= lkFrame;
            lastGroup        <= group_r;
            anyFrameSet      <= |frame_select_bits_r;
            badPacket        <= ownIdBad;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_enable_load: assert property (@(posedge clk_sys) disable iff (rst)
        isEnable |=> enable_r == $past(pktLow))
        else $error("enable mask not loaded");

    a_enable_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !isEnable |=> $stable(enable_r))
        else $error("enable mask changed without packet");

    a_frame_map: assert property (@(posedge clk_sys) disable iff (rst)
        isFrame |=> frame_select_bits_r[(7 - $past(wrGroup)) * 16 +: 16]
                    == $past(pktLow))
        else $error("frame group mapped wrongly");

    a_slot_write: assert property (@(posedge clk_sys) disable iff (rst)
        isSlot |=> addr_r[$past(wrSlot)] == $past(pkt[ADDR_BITS-1:0])
                   && long_r[$past(wrSlot)] == $past(pkt[POS_LONG]))
        else $error("slot fields not stored");

    a_silent_write: assert property (@(posedge clk_sys) disable iff (rst)
        isSlot |=> silent_r[$past(wrSlot)] == $past(pkt[POS_SILENT]))
        else $error("silent flag not stored");

    a_report_odd: assert property (@(posedge clk_sys) disable iff (rst)
        slotActive |-> slotReportable == (!slotLong || $past(lookupSlot[0])))
        else $error("first word of long pair reported");

    a_active_path: assert property (@(posedge clk_sys) disable iff (rst)
        slotActive |-> $past(enable_r[lookupSlot]))
        else $error("slot active while disabled");

    a_frame_out: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 frameDecode == $past(frame_select_bits_r[lookupFrame]))
        else $error("frame decode output wrong");

    a_bad_frame: assert property (@(posedge clk_sys) disable iff (rst)
        (pktValid && pktId[7:3] == ID_FRAME_HI && pktByte2 != 8'h00)
        |=> badPacket && $stable(frame_select_bits_r))
        else $error("malformed frame packet accepted");

    // ------------------------------------------------------------------
    // checks on refused and foreign packets
    // ------------------------------------------------------------------
    // a refused packet must leave a trace for the host's driver
    a_bad_slot: assert property (@(posedge clk_sys) disable iff (rst)
        (pktValid && pktId[7:4] == ID_SLOT_HI && pkt[POS_ZERO])
        |=> badPacket)
        else $error("malformed slot packet not flagged");

    a_bad_enable: assert property (@(posedge clk_sys) disable iff (rst)
        (pktValid && pktId == ID_ENABLE && pktByte2 != BYTE2_ZERO)
        |=> badPacket && $stable(enable_r))
        else $error("malformed enable packet accepted");

    // control and phase packets belong to other blocks and pass silently
    a_other_ids: assert property (@(posedge clk_sys) disable iff (rst)
        (pktValid && pktId[7:4] != ID_SLOT_HI && pktId != ID_ENABLE
         && pktId[7:3] != ID_FRAME_HI)
        |=> !badPacket && $stable(enable_r) && $stable(group_r))
        else $error("foreign packet changed configuration");

    // ------------------------------------------------------------------
    // checks on reset and group selection
    // ------------------------------------------------------------------
    // sampled at the second reset edge, once the async clear has landed
    a_reset_clear: assert property (@(posedge clk_sys)
        (rst && $past(rst)) |-> enable_r == ENABLE_RST[SLOTS-1:0]
        && group_r == GROUP_RST && frame_select_bits_r == '0)
        else $error("reset left configuration set");

    a_group_load: assert property (@(posedge clk_sys) disable iff (rst)
        isFrame |=> group_r == $past(wrGroup))
        else $error("group select not stored");

    a_group_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !isFrame |=> $stable(group_r))
        else $error("group select changed without packet");

    // a stray write into any group would silently widen the wake schedule
    a_frame_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !isFrame |=> $stable(frame_select_bits_r))
        else $error("frame mask changed without packet");

    // ------------------------------------------------------------------
    // checks on the registered lookup outputs
    // ------------------------------------------------------------------
    // a disabled slot must not leak its unreset storage
    a_addr_masked: assert property (@(posedge clk_sys) disable iff (rst)
        !slotActive |-> slotAddr == '0 && !slotLong && !slotSilent)
        else $error("disabled slot contents visible");

    // every registered copy trails its source by exactly one cycle
    a_enable_out: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 slot_enable_bits == $past(enable_r))
        else $error("enable copy wrong");

    a_group_out: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 lastGroup == $past(group_r))
        else $error("group output wrong");

    a_frame_any: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 anyFrameSet == $past(|frame_select_bits_r))
        else $error("any frame output wrong");

    a_long_out: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 slotLong == $past(enable_r[lookupSlot] && long_r[lookupSlot]))
        else $error("long flag output wrong");

    a_silent_out: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 slotSilent
            == $past(enable_r[lookupSlot] && silent_r[lookupSlot]))
        else $error("silent flag output wrong");
endmodule
`default_nettype wire

// ---- pafc_pkg.sv ----
// shared constants for the pager address and frame configuration store
package pafc_pkg;
    // ------------------------------------------------------------------
    // packet layout
    // ------------------------------------------------------------------
    localparam int          PKT_BITS       = 32;
    localparam int          SLOT_COUNT     = 16;
    localparam int          SLOT_IDX_BITS  = 4;
    localparam int          ADDR_BITS      = 21;
    localparam int          GROUP_COUNT    = 8;
    localparam int          GROUP_BITS     = 3;
    localparam int          FRAME_COUNT    = 128;
    localparam int          FRAMES_PER_GRP = 16;
    // identifier byte values and masks
    localparam logic [3:0]  ID_SLOT_HI     = 4'h8;
    localparam logic [7:0]  ID_ENABLE      = 8'h78;
    localparam logic [4:0]  ID_FRAME_HI    = 5'h04;
    // field positions inside byte 2 of a slot packet
    localparam int          POS_ZERO       = 23;
    localparam int          POS_LONG       = 22;
    localparam int          POS_SILENT     = 21;
    // reset values and the required zero byte 2
    localparam logic [15:0] ENABLE_RST     = 16'h0000;
    localparam logic [2:0]  GROUP_RST      = 3'h0;
    localparam logic [7:0]  BYTE2_ZERO     = 8'h00;
endpackage

// ---- pafc_link_rx.sv ----
// serial link receiver: shifts 32-bit packets on the link clock
`timescale 1ns/10ps
`default_nettype none
module pafc_link_rx (
    input  wire logic                        linkClk,
    input  wire logic                        rst,
    input  wire logic                        selectN,
    input  wire logic                        mosi,
    input  wire logic                        clk_sys,
    output logic [pafc_pkg::PKT_BITS-1:0]    pktData,
    output logic                             pktValid
);
    import pafc_pkg::*;

    // ------------------------------------------------------------------
    // link domain shifter
    // ------------------------------------------------------------------
    logic [PKT_BITS-1:0] shift_r;
    logic [4:0]          bitCnt_r;
    logic [PKT_BITS-1:0] hold_r;
    logic                toggle_r;
    wire  [PKT_BITS-1:0] shiftNext = {shift_r[PKT_BITS-2:0], mosi};
    wire                 lastBit   = (bitCnt_r == 5'h1F);

    // msb first; select high aborts a partial packet
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            shift_r  <= '0;
            bitCnt_r <= 5'h00;
            hold_r   <= '0;
            toggle_r <= 1'b0;
        end else if (selectN) begin
            bitCnt_r <= 5'h00;
        end else begin
            shift_r  <= shiftNext;
            bitCnt_r <= bitCnt_r + 5'h01;
            if (lastBit) begin
                hold_r   <= shiftNext;
                toggle_r <= ~toggle_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // crossing into the system clock
    // ------------------------------------------------------------------
    // hold_r is stable for many link edges after a toggle, so it is
    // sampled only once the toggle has passed two flops
    logic [2:0] sync_r;
    wire        arrived = sync_r[2] ^ sync_r[1];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync_r   <= 3'h0;
            pktData  <= '0;
            pktValid <= 1'b0;
        end else begin
            sync_r   <= {sync_r[1:0], toggle_r};
            pktValid <= arrived;
            if (arrived) begin
                pktData <= hold_r;
            end
        end
    end
endmodule
`default_nettype wire

// ---- pafc_host_model.sv ----
// host side of the serial link: shifts one 32-bit packet per request
`timescale 1ns/10ps
`default_nettype none
module pafc_host_model (
    input  wire logic        go,
    input  wire logic [31:0] word,
    output var logic         busy,
    output var logic         linkClk,
    output var logic         selectN,
    output var logic         mosi
);
    // ------------------------------------------------------------------
    // packet shifter
    // ------------------------------------------------------------------
    // the link clock only runs inside a frame; an odd start offset keeps
    // its phase unrelated to the system clock
    initial begin
        linkClk = 1'b0;
        selectN = 1'b1;
        mosi    = 1'b0;
        busy    = 1'b0;
        #3.3;
        forever begin
            @(posedge go);
            busy    = 1'b1;
            selectN = 1'b0;
            for (int i = 31; i >= 0; i--) begin
                mosi = word[i];
                #7.5 linkClk = 1'b1;
                #7.5 linkClk = 1'b0;
            end
            mosi = ~mosi; // released line must not hold the last bit
            #7.5 selectN = 1'b1;
            busy = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- test_pager_address_frame_config.sv ----
// self-checking bench for the slot, enable and frame configuration store
`timescale 1ns/10ps
`default_nettype none
module test_pager_address_frame_config;
    import pafc_pkg::*;
    logic                 clk_sys, rst, go, busy, linkClk, selectN, mosi;
    logic [31:0]          word;
    logic [3:0]           lookupSlot;
    logic [6:0]           lookupFrame;
    logic [ADDR_BITS-1:0] slotAddr;
    logic                 slotLong, slotSilent, slotActive, slotReportable;
    logic                 frameDecode, anyFrameSet, badPacket, badSeen;
    logic [15:0]          slot_enable_bits, enMask, grp;
    logic [2:0]           lastGroup;
    logic [23:0]          slotCfg [16];
    logic [127:0]         frames;
    int                   miscompares, cmp_count;

    pafc_config pafc_config_i (.clk_sys(clk_sys), .rst(rst),
        .linkClk(linkClk), .selectN(selectN), .mosi(mosi),
        .lookupSlot(lookupSlot), .lookupFrame(lookupFrame),
        .slotAddr(slotAddr), .slotLong(slotLong), .slotSilent(slotSilent),
        .slotActive(slotActive), .slotReportable(slotReportable),
        .slot_enable_bits(slot_enable_bits), .frameDecode(frameDecode),
        .lastGroup(lastGroup), .anyFrameSet(anyFrameSet),
        .badPacket(badPacket));
    pafc_host_model pafc_host_model_i (.go(go), .word(word), .busy(busy),
        .linkClk(linkClk), .selectN(selectN), .mosi(mosi));

    // ------------------------------------------------------------------
    // clock, pulse catcher, watchdog
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // error pulse lasts one cycle, so latch it for later inspection
    always @(posedge clk_sys) if (badPacket === 1'b1) badSeen <= 1'b1;
    initial begin
        #2000000;
        miscompares++;
        results();
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic int frameIdx(input int g, input int k);
        return (7 - g) * 16 + k;
    endfunction
    // frames a collapsed address wakes for: base plus steps, modulo 128
    function automatic logic [127:0] collapseMask(input int base,
                                                  input int c);
        logic [127:0] m;
        m = '0;
        for (int n = 0; n < 128; n++) begin
            m[n] = ((n + 128 - base) % (1 << c)) == 0;
        end
        return m;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %0h expected %0h", $time, what,
                     got, exp);
        end
    endtask
    // storage settles a few system cycles after the frame closes
    task automatic send(input logic [31:0] w);
        @(negedge clk_sys);
        word = w;
        go   = 1'b1;
        @(negedge clk_sys);
        go = 1'b0;
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk_sys);
        chk(busy, 0, "link idle");
        repeat (8) @(negedge clk_sys);
    endtask
    task automatic look(input int s, input int f);
        lookupSlot  = s[3:0];
        lookupFrame = f[6:0];
        repeat (3) @(negedge clk_sys);
    endtask
    task automatic chkSlot(input int s);
        logic en, lg;
        en = enMask[s];
        lg = slotCfg[s][POS_LONG];
        look(s, 0);
        chk(slotAddr, en ? slotCfg[s][20:0] : 0, "address");
        chk(slotLong, en & lg, "long flag");
        chk(slotSilent, en & slotCfg[s][POS_SILENT], "silent flag");
        chk(slotActive, en, "active");
        chk(slotReportable, en & (~lg | s[0]), "reportable");
    endtask
    // long pairs share flags and start on an even slot; addresses are
    // not sorted into sets, so every pair counts as one set
    task automatic writeSlots();
        logic lg, tn;
        for (int s = 0; s < 16; s++) begin
            if (s[0] == 1'b0) begin
                lg = 1'($urandom_range(0, 1));
                tn = 1'($urandom_range(0, 1));
            end
            slotCfg[s] = {1'b0, lg, tn,
                          21'($urandom_range(1, 21'h1FFFFE))};
            send({ID_SLOT_HI, 4'(s), slotCfg[s]});
        end
    endtask
    // the whole frame vector goes out as eight group packets
    task automatic writeFrames();
        for (int g = 0; g < 8; g++) begin
            for (int k = 0; k < 16; k++) grp[k] = frames[frameIdx(g, k)];
            send({ID_FRAME_HI, 3'(g), BYTE2_ZERO, grp});
            chk(lastGroup, g, "group select");
        end
    endtask
    task automatic checkFrames();
        for (int f = 0; f < 128; f++) begin
            look(0, f);
            chk(frameDecode, frames[f], "frame bit");
        end
        chk(anyFrameSet, |frames, "any frame");
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        go = 1'b0;
        word = 32'h0;
        lookupSlot = 4'h0;
        lookupFrame = 7'h00;
        badSeen = 1'b0;
        enMask = 16'h0000;
        frames = 128'h0;
        void'($urandom(32'h94F2868A));
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        look(0, 0);
        chk(slot_enable_bits, ENABLE_RST, "enable reset");
        chk(slotActive, 0, "slot reset");
        chk(anyFrameSet, 0, "frames reset");
        chk(lastGroup, GROUP_RST, "group reset");
        $display("test reset done");
        writeSlots();
        enMask = 16'($urandom);
        send({ID_ENABLE, BYTE2_ZERO, enMask});
        chk(slot_enable_bits, enMask, "enable mask");
        for (int s = 0; s < 16; s++) chkSlot(s);
        enMask = 16'h0000;
        send({ID_ENABLE, BYTE2_ZERO, enMask});
        writeSlots();
        enMask = 16'h8001;
        send({ID_ENABLE, BYTE2_ZERO, enMask});
        for (int s = 0; s < 16; s++) chkSlot(s);
        $display("test slots done");
        send({ID_FRAME_HI, 3'h0, BYTE2_ZERO, 16'h8000});
        look(0, 127);
        chk(frameDecode, 1, "frame 127");
        chk(anyFrameSet, 1, "any frame");
        frames = {$urandom, $urandom, $urandom, $urandom};
        writeFrames();
        checkFrames();
        frames = collapseMask(3, 4);
        writeFrames();
        checkFrames();
        frames = collapseMask($urandom_range(0, 127), $urandom_range(0, 5));
        writeFrames();
        checkFrames();
        badSeen = 1'b0;
        send({ID_FRAME_HI, 3'h2, 8'h01, 16'hFFFF});
        chk(badSeen, 1, "bad frame flagged");
        chk(lastGroup, 3'h7, "group kept");
        checkFrames();
        $display("test frames done");
        badSeen = 1'b0;
        send({ID_ENABLE, 8'h01, 16'hFFFF});
        chk(slot_enable_bits, enMask, "refused enable");
        chk(badSeen, 1, "bad enable flagged");
        badSeen = 1'b0;
        send({ID_SLOT_HI, 4'h0, 8'h80, 16'h1234});
        chkSlot(0);
        chk(badSeen, 1, "bad slot flagged");
        badSeen = 1'b0;
        send({8'h30, 24'hFFFFFF});
        chkSlot(15);
        chk(badSeen, 0, "foreign id quiet");
        $display("test refusals done");
        // a second reset with live state must clear the enable mask, frame mask and group select again
        @(negedge clk_sys);
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        look(15, 127);
        chk(slot_enable_bits, ENABLE_RST, "enable rerun reset");
        chk(slotActive, 0, "slot rerun reset");
        chk(frameDecode, 0, "frame rerun reset");
        chk(anyFrameSet, 0, "frames rerun reset");
        chk(lastGroup, GROUP_RST, "group rerun reset");
        $display("test rerun reset done");
        results();
    end
endmodule
`default_nettype wire
